/* File: src/mdlp_parser.sv */
// Descriptor list parser for transport and program stream forms
// What the document requires
// RQ1: Transport entry: 3 reserved, 13-bit id, 16-bit length.
// RQ2: Consume exactly entry length bytes of descriptors.
// RQ3: Sender keeps time stamps in section lists.
// RQ4: Program packet: prefix, stream id, length, discriminator.
// RQ5: Accept program packet only with stream id f2.
// RQ6: Packet length bounds bytes consumed after it.
// RQ7: Discriminator must be 80 before list parsing.
// RQ8: Entry id compared with selected stream id.
// RQ9: Entry length bounds that entry's descriptor loop.
// RQ10: Refuse lists from first-generation system streams.
// RQ11: Fields assembled most significant byte first.
// RQ12: Overrunning entry length flags error, resynchronises.
`default_nettype none
module mdlp_parser (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    input wire logic i_sof,
    input wire logic i_ps_mode,
    input wire logic i_sys1,
    input wire logic [15:0] i_list_len,
    input wire logic [12:0] i_sel_id,
    output logic o_entry_valid,
    output logic [12:0] o_entry_id,
    output logic [15:0] o_entry_len,
    output logic o_entry_sel,
    output logic o_desc_valid,
    output logic [7:0] o_desc_data,
    output logic o_desc_last,
    output logic o_desc_sel,
    output logic o_done,
    output logic o_err,
    output logic o_reject,
    output logic o_busy
);
    mdlp_field_if fld ();

    mdlp_field_asm u_asm (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .f(fld.asm)
    );

    mdlp_pkg::mdlp_state_t st_q, st_d;
    logic [1:0] cnt_q, cnt_d;
    logic [15:0] rem_q, rem_d;
    logic [15:0] ent_q, ent_d;
    logic ps_q, ps_d;
    logic sel_q, sel_d;
    logic ev_valid_d, ev_sel_d, dv_d, dlast_d, done_d, err_d, rej_d;
    logic dsel_d, busy_d;
    logic [7:0] ddata_d;
    logic [12:0] ev_id_d;
    logic [15:0] ev_len_d;
    logic [15:0] rem_m1;
    logic [15:0] hdr_len;
    logic [12:0] hdr_id;
    logic [7:0] pfx_byte;

    assign rem_m1 = rem_q - 16'h0001;
    assign hdr_len = fld.nxt[mdlp_pkg::LEN_W-1:0];

    // Identifier field differs in width and reserved bits between the two forms
    always_comb begin
        if (ps_q) begin
            hdr_id = {5'h00, fld.nxt[mdlp_pkg::PS_ID_LSB +: mdlp_pkg::PS_ID_W]}; // RQ8
        end else begin
            hdr_id = fld.nxt[mdlp_pkg::TS_PID_LSB +: mdlp_pkg::TS_PID_W]; // RQ1
        end
    end

    always_comb begin
        case (cnt_q)
            2'h0: pfx_byte = mdlp_pkg::PS_PREFIX[23:16];
            2'h1: pfx_byte = mdlp_pkg::PS_PREFIX[15:8];
            default: pfx_byte = mdlp_pkg::PS_PREFIX[7:0];
        endcase
    end

    // ******************************************************
    // Parse sequencer
    // ******************************************************
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        rem_d = rem_q;
        ent_d = ent_q;
        ps_d = ps_q;
        sel_d = sel_q;
        ev_valid_d = 1'b0;
        ev_sel_d = 1'b0;
        ev_id_d = o_entry_id;
        ev_len_d = o_entry_len;
        dv_d = 1'b0;
        dlast_d = 1'b0;
        done_d = 1'b0;
        err_d = 1'b0;
        rej_d = 1'b0;
        ddata_d = o_desc_data;
        dsel_d = o_desc_sel;
        fld.clr = 1'b0;
        fld.shift = 1'b0;
        fld.data = i_data;
        if (i_valid && i_sof) begin
            // A new start always resynchronises, whatever the state
            fld.clr = 1'b1;
            ps_d = i_ps_mode;
            if (i_sys1) begin
                rej_d = 1'b1; // RQ10
                st_d = mdlp_pkg::ST_SKIP;
            end else if (i_ps_mode) begin
                cnt_d = 2'h1;
                if (i_data == mdlp_pkg::PS_PREFIX[23:16]) begin // RQ4
                    st_d = mdlp_pkg::ST_PFX;
                end else begin
                    err_d = 1'b1;
                    st_d = mdlp_pkg::ST_SKIP;
                end
            end else if (i_list_len == 16'h0000) begin
                err_d = 1'b1;
                st_d = mdlp_pkg::ST_SKIP;
            end else begin
                fld.clr = 1'b0;
                fld.shift = 1'b1;
                rem_d = i_list_len - 16'h0001;
                cnt_d = 2'h1;
                st_d = (i_list_len == 16'h0001) ? mdlp_pkg::ST_SKIP : mdlp_pkg::ST_ENT;
                err_d = (i_list_len == 16'h0001);
            end
        end else if (i_valid) begin
            case (st_q)
                mdlp_pkg::ST_PFX: begin
                    cnt_d = cnt_q + 2'h1;
                    if (i_data != pfx_byte) begin // RQ4
                        err_d = 1'b1;
                        st_d = mdlp_pkg::ST_SKIP;
                    end else if (cnt_q == mdlp_pkg::PS_PFX_LAST) begin
                        st_d = mdlp_pkg::ST_SID;
                    end
                end
                mdlp_pkg::ST_SID: begin
                    cnt_d = 2'h0;
                    if (i_data == mdlp_pkg::PS_LIST_SID) begin // RQ5
                        st_d = mdlp_pkg::ST_PLEN;
                    end else begin
                        rej_d = 1'b1;
                        st_d = mdlp_pkg::ST_SKIP;
                    end
                end
                mdlp_pkg::ST_PLEN: begin
                    fld.shift = 1'b1;
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q == mdlp_pkg::PS_LEN_LAST) begin
                        rem_d = hdr_len; // RQ6
                        if (hdr_len == 16'h0000) begin
                            err_d = 1'b1;
                            st_d = mdlp_pkg::ST_SKIP;
                        end else begin
                            st_d = mdlp_pkg::ST_DISC;
                        end
                    end
                end
                mdlp_pkg::ST_DISC: begin
                    rem_d = rem_m1;
                    cnt_d = 2'h0;
                    fld.clr = 1'b1;
                    if (i_data != mdlp_pkg::PS_DISC_VAL) begin // RQ7
                        rej_d = 1'b1;
                        st_d = mdlp_pkg::ST_SKIP;
                    end else if (rem_m1 == 16'h0000) begin
                        done_d = 1'b1;
                        st_d = mdlp_pkg::ST_IDLE;
                    end else begin
                        st_d = mdlp_pkg::ST_ENT;
                    end
                end
                mdlp_pkg::ST_ENT: begin
                    fld.shift = 1'b1;
                    rem_d = rem_m1; // RQ6
                    cnt_d = cnt_q + 2'h1;
                    if (cnt_q == (ps_q ? mdlp_pkg::PS_HDR_LAST : mdlp_pkg::TS_HDR_LAST)) begin
                        cnt_d = 2'h0;
                        if (hdr_len > rem_m1) begin
                            err_d = 1'b1; // RQ12
                            st_d = mdlp_pkg::ST_SKIP;
                        end else begin
                            ev_valid_d = 1'b1;
                            ev_id_d = hdr_id;
                            ev_len_d = hdr_len;
                            ev_sel_d = (hdr_id == i_sel_id); // RQ8
                            sel_d = (hdr_id == i_sel_id);
                            ent_d = hdr_len; // RQ9
                            if (hdr_len != 16'h0000) begin
                                st_d = mdlp_pkg::ST_DESC;
                            end else if (rem_m1 == 16'h0000) begin
                                done_d = 1'b1;
                                st_d = mdlp_pkg::ST_IDLE;
                            end
                        end
                    end else if (rem_m1 == 16'h0000) begin
                        err_d = 1'b1; // RQ12
                        st_d = mdlp_pkg::ST_SKIP;
                    end
                end
                mdlp_pkg::ST_DESC: begin
                    dv_d = 1'b1;
                    ddata_d = i_data;
                    dsel_d = sel_q;
                    rem_d = rem_m1;
                    ent_d = ent_q - 16'h0001; // RQ2
                    if (ent_q == 16'h0001) begin
                        dlast_d = 1'b1; // RQ9
                        if (rem_m1 == 16'h0000) begin
                            done_d = 1'b1; // RQ6
                            st_d = mdlp_pkg::ST_IDLE;
                        end else begin
                            st_d = mdlp_pkg::ST_ENT;
                        end
                    end
                end
                default: begin
                    st_d = st_q;
                end
            endcase
        end
        busy_d = (st_d != mdlp_pkg::ST_IDLE) && (st_d != mdlp_pkg::ST_SKIP);
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= mdlp_pkg::ST_IDLE;
            cnt_q <= 2'h0;
            rem_q <= 16'h0000;
            ent_q <= 16'h0000;
            ps_q <= 1'b0;
            sel_q <= 1'b0;
            o_entry_valid <= 1'b0;
            o_entry_id <= 13'h0000;
            o_entry_len <= 16'h0000;
            o_entry_sel <= 1'b0;
            o_desc_valid <= 1'b0;
            o_desc_data <= 8'h00;
            o_desc_last <= 1'b0;
            o_desc_sel <= 1'b0;
            o_done <= 1'b0;
            o_err <= 1'b0;
            o_reject <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rem_q <= rem_d;
            ent_q <= ent_d;
            ps_q <= ps_d;
            sel_q <= sel_d;
            o_entry_valid <= ev_valid_d;
            o_entry_id <= ev_id_d;
            o_entry_len <= ev_len_d;
            o_entry_sel <= ev_sel_d;
            o_desc_valid <= dv_d;
            o_desc_data <= ddata_d;
            o_desc_last <= dlast_d;
            o_desc_sel <= dsel_d;
            o_done <= done_d;
            o_err <= err_d;
            o_reject <= rej_d;
            o_busy <= busy_d;
        end
    end
endmodule
`default_nettype wire

/* File: src/mdlp_pkg.sv */
// Shared constants and types of the media descriptor list parser
`default_nettype none
package mdlp_pkg;
    localparam logic [23:0] PS_PREFIX = 24'h000001;
    localparam logic [7:0] PS_LIST_SID = 8'hf2;
    localparam logic [7:0] PS_DISC_VAL = 8'h80;
    localparam logic [1:0] TS_HDR_LAST = 2'h3;
    localparam logic [1:0] PS_HDR_LAST = 2'h2;
    localparam logic [1:0] PS_PFX_LAST = 2'h2;
    localparam logic [1:0] PS_LEN_LAST = 2'h1;
    localparam int TS_PID_LSB = 16;
    localparam int TS_PID_W = 13;
    localparam int PS_ID_LSB = 16;
    localparam int PS_ID_W = 8;
    localparam int LEN_W = 16;
    localparam int FIELD_W = 32;
    localparam logic [2:0] CNT_RST = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PFX = 3'b001,
        ST_SID = 3'b010,
        ST_PLEN = 3'b011,
        ST_DISC = 3'b100,
        ST_ENT = 3'b101,
        ST_DESC = 3'b110,
        ST_SKIP = 3'b111
    } mdlp_state_t;
endpackage
`default_nettype wire

/* File: src/mdlp_field_if.sv */
// Carrier between the parser and its field assembler
`default_nettype none
interface mdlp_field_if;
    logic clr;
    logic shift;
    logic [7:0] data;
    logic [mdlp_pkg::FIELD_W-1:0] nxt;
    modport ctrl (output clr, output shift, output data, input nxt);
    modport asm (input clr, input shift, input data, output nxt);
endinterface
`default_nettype wire

/* File: src/mdlp_field_asm.sv */
// Big-endian field assembler for stream bytes
`default_nettype none
module mdlp_field_asm (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    mdlp_field_if.asm f
);
    logic [mdlp_pkg::FIELD_W-1:0] val_q;
    logic [mdlp_pkg::FIELD_W-1:0] val_d;

    // Newest byte enters at the bottom, so earlier bytes end up most significant
    always_comb begin
        f.nxt = {val_q[mdlp_pkg::FIELD_W-9:0], f.data}; // RQ11
        val_d = val_q;
        if (f.clr) begin
            val_d = '0;
        end else if (f.shift) begin
            val_d = f.nxt;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            val_q <= '0;
        end else begin
            val_q <= val_d;
        end
    end
endmodule
`default_nettype wire

/* File: bench/mdlp_src.sv */
// Upstream demultiplexer model that hands list bytes to the parser
`default_nettype none
module mdlp_src (
    input wire logic i_mclk,
    output var logic o_valid,
    output var logic o_sof,
    output var logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_valid = 1'b0;
        o_sof = 1'b0;
        o_data = 8'h5a;
    end
    // Whole list goes out back to back, first byte flagged
    task automatic send(input logic [7:0] b[$]);
        for (int i = 0; i < b.size(); i++) begin
            @(negedge i_mclk);
            o_valid = 1'b1;
            o_sof = (i == 0);
            o_data = b[i];
        end
        @(negedge i_mclk);
        o_valid = 1'b0;
        o_sof = 1'b0;
        // Idle bytes are inverted so a stale value is never trusted
        o_data = ~o_data;
    endtask
endmodule
`default_nettype wire

/* File: bench/mdlp_parser_sva.sv */
// Port assertions of the descriptor list parser
`default_nettype none
module mdlp_parser_sva (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic i_sof,
    input wire logic i_ps_mode,
    input wire logic i_sys1,
    input wire logic [15:0] i_list_len,
    input wire logic [12:0] i_sel_id,
    input wire logic o_entry_valid,
    input wire logic [12:0] o_entry_id,
    input wire logic o_entry_sel,
    input wire logic o_desc_valid,
    input wire logic o_desc_last,
    input wire logic o_done,
    input wire logic o_err,
    input wire logic o_reject,
    input wire logic o_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    property p_sel; o_entry_sel |-> o_entry_valid; endproperty
    a_sel: assert property (p_sel) else $error("select without entry");
    property p_match; o_entry_valid |-> o_entry_sel == (o_entry_id == $past(i_sel_id)); endproperty
    a_match: assert property (p_match) else $error("select compare wrong");
    property p_last; o_desc_last |-> o_desc_valid; endproperty
    a_last: assert property (p_last) else $error("last without byte");
    property p_done; o_done |-> !o_busy && !o_err; endproperty
    a_done: assert property (p_done) else $error("done while busy");
    property p_desc; o_desc_valid |-> $past(i_valid); endproperty
    a_desc: assert property (p_desc) else $error("byte without input");
    property p_sys1; i_valid && i_sof && i_sys1 |=> o_reject; endproperty
    a_sys1: assert property (p_sys1) else $error("system stream kept");
    property p_short; i_valid && i_sof && !i_ps_mode && !i_sys1 && i_list_len < 16'h0002 |=> o_err;
    endproperty
    a_short: assert property (p_short) else $error("short list kept");
    property p_rej; o_reject |-> !o_entry_valid && !o_desc_valid && !o_done; endproperty
    a_rej: assert property (p_rej) else $error("output on reject");
    c_done: cover property (o_done && o_desc_last);
    c_rej: cover property (o_reject);
    c_err: cover property (o_err);
endmodule
bind mdlp_parser mdlp_parser_sva u_sva (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_valid(i_valid),
    .i_sof(i_sof),
    .i_ps_mode(i_ps_mode),
    .i_sys1(i_sys1),
    .i_list_len(i_list_len),
    .i_sel_id(i_sel_id),
    .o_entry_valid(o_entry_valid),
    .o_entry_id(o_entry_id),
    .o_entry_sel(o_entry_sel),
    .o_desc_valid(o_desc_valid),
    .o_desc_last(o_desc_last),
    .o_done(o_done),
    .o_err(o_err),
    .o_reject(o_reject),
    .o_busy(o_busy)
);
`default_nettype wire

/* File: bench/mdlp_parser_tb.sv */
// Self-checking bench of the descriptor list parser
`default_nettype none
module mdlp_parser_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ps_mode = 1'b0;
    logic i_sys1 = 1'b0;
    logic [15:0] i_list_len = 16'h0000;
    logic [12:0] i_sel_id = 13'h0000;
    wire logic i_valid;
    wire logic i_sof;
    wire logic [7:0] i_data;
    logic o_entry_valid, o_entry_sel, o_desc_valid, o_desc_last, o_desc_sel;
    logic o_done, o_err, o_reject, o_busy;
    logic [12:0] o_entry_id;
    logic [15:0] o_entry_len;
    logic [7:0] o_desc_data;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_ent, n_sel, n_last, n_done, n_err, n_rej, n_dsel, n_busy;
    logic [12:0] ent_id;
    logic [15:0] ent_len;
    logic [7:0] got[$];
    logic [7:0] b[$];
    mdlp_src u_src (.i_mclk(i_mclk), .o_valid(i_valid), .o_sof(i_sof), .o_data(i_data));
    mdlp_parser DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_data(i_data),
        .i_sof(i_sof), .i_ps_mode(i_ps_mode), .i_sys1(i_sys1), .i_list_len(i_list_len),
        .i_sel_id(i_sel_id), .o_entry_valid(o_entry_valid), .o_entry_id(o_entry_id),
        .o_entry_len(o_entry_len), .o_entry_sel(o_entry_sel), .o_desc_valid(o_desc_valid),
        .o_desc_data(o_desc_data), .o_desc_last(o_desc_last), .o_desc_sel(o_desc_sel),
        .o_done(o_done), .o_err(o_err), .o_reject(o_reject), .o_busy(o_busy));
    initial forever #50 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            final_report();
        end
    end
    // Outputs settle by the falling edge
    always @(negedge i_mclk) begin
        if (o_entry_valid === 1'b1) begin
            n_ent++;
            ent_id = o_entry_id;
            ent_len = o_entry_len;
        end
        if (o_entry_sel === 1'b1) n_sel++;
        if (o_desc_valid === 1'b1) got.push_back(o_desc_data);
        if (o_desc_last === 1'b1) n_last++;
        if (o_done === 1'b1) n_done++;
        if (o_err === 1'b1) n_err++;
        if (o_reject === 1'b1) n_rej++;
        if (o_desc_valid === 1'b1 && o_desc_sel === 1'b1) n_dsel++;
        if (o_busy === 1'b1) n_busy++;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic run(input logic ps, input logic s1, input logic [15:0] len,
        input logic [12:0] sel);
        @(negedge i_mclk);
        i_ps_mode = ps;
        i_sys1 = s1;
        i_list_len = len;
        i_sel_id = sel;
        {n_ent, n_sel, n_last, n_done, n_err, n_rej, n_dsel, n_busy} = '0;
        got.delete();
        u_src.send(b);
        repeat (3) @(negedge i_mclk);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_ts();
        b = '{8'h1f, 8'hff, 8'h00, 8'h02, 8'haa, 8'hbb, 8'he1, 8'h23, 8'h00, 8'h00};
        run(1'b0, 1'b0, 16'h000a, 13'h0123);
        chk("entries", n_ent, 16'h0002);
        chk("pid", ent_id, 13'h0123);
        chk("length", ent_len, 16'h0000);
        chk("bytes", got.size(), 16'h0002);
        chk("byte1", got[1], 8'hbb);
        chk("last", n_last, 16'h0001);
        chk("done", n_done, 16'h0001);
        chk("sel", n_sel, 16'h0001);
        chk("desc sel", n_dsel, 16'h0000);
        chk("busy cycles", n_busy, 16'h0009);
    endtask
    task automatic t_bad_len();
        b = '{8'h00, 8'h10, 8'h00, 8'h05, 8'haa, 8'hbb};
        run(1'b0, 1'b0, 16'h0006, 13'h0000);
        chk("overrun err", n_err, 16'h0001);
        chk("overrun done", n_done, 16'h0000);
        b = '{8'h00};
        run(1'b0, 1'b0, 16'h0001, 13'h0000);
        chk("short err", n_err, 16'h0001);
    endtask
    task automatic t_ps();
        b = '{8'h00, 8'h00, 8'h01, 8'hf2, 8'h00, 8'h05, 8'h80, 8'he0, 8'h00, 8'h01, 8'hcc, 8'hdd};
        run(1'b1, 1'b0, 16'h0000, 13'h00e0);
        chk("ps entries", n_ent, 16'h0001);
        chk("ps id", ent_id, 13'h00e0);
        chk("ps len", ent_len, 16'h0001);
        chk("ps bytes", got.size(), 16'h0001);
        chk("ps byte", got[0], 8'hcc);
        chk("ps done", n_done, 16'h0001);
        chk("ps sel", n_sel, 16'h0001);
        chk("ps desc sel", n_dsel, 16'h0001);
        chk("ps busy cycles", n_busy, 16'h000a);
    endtask
    task automatic t_reject();
        b = '{8'h00, 8'h00, 8'h01, 8'hf3, 8'h00, 8'h01, 8'h80};
        run(1'b1, 1'b0, 16'h0000, 13'h0000);
        chk("sid rej", n_rej, 16'h0001);
        b[3] = 8'hf2;
        b[6] = 8'h81;
        run(1'b1, 1'b0, 16'h0000, 13'h0000);
        chk("disc rej", n_rej, 16'h0001);
        b[6] = 8'h80;
        run(1'b1, 1'b1, 16'h0000, 13'h0000);
        chk("sys rej", n_rej, 16'h0001);
        chk("sys done", n_done, 16'h0000);
    endtask
    // Bad prefix, empty packet, cut header, then a new start in mid-list
    task automatic t_err();
        b = '{8'h00, 8'h01, 8'h01, 8'hf2};
        run(1'b1, 1'b0, 16'h0000, 13'h0000);
        chk("prefix err", n_err, 16'h0001);
        chk("prefix rej", n_rej, 16'h0000);
        b = '{8'h00, 8'h00, 8'h01, 8'hf2, 8'h00, 8'h00};
        run(1'b1, 1'b0, 16'h0000, 13'h0000);
        chk("zero plen err", n_err, 16'h0001);
        b = '{8'h00, 8'h20, 8'h00};
        run(1'b0, 1'b0, 16'h0003, 13'h0000);
        chk("cut hdr err", n_err, 16'h0001);
        chk("cut hdr ent", n_ent, 16'h0000);
        b = '{8'h00, 8'h20, 8'h00, 8'h04, 8'haa};
        run(1'b0, 1'b0, 16'h000a, 13'h0020);
        chk("part ent", n_ent, 16'h0001);
        chk("part done", n_done, 16'h0000);
        chk("part byte", got[0], 8'haa);
        chk("part desc sel", n_dsel, 16'h0001);
        b = '{8'h00, 8'h21, 8'h00, 8'h01, 8'hbb};
        run(1'b0, 1'b0, 16'h0005, 13'h0020);
        chk("resync ent", n_ent, 16'h0001);
        chk("resync id", ent_id, 13'h0021);
        chk("resync byte", got[0], 8'hbb);
        chk("resync done", n_done, 16'h0001);
        chk("resync err", n_err, 16'h0000);
        chk("resync desc sel", n_dsel, 16'h0000);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_n = 1'b1;
        chk("busy at reset", o_busy, 1'b0);
        t_ts();
        t_bad_len();
        t_ps();
        t_reject();
        t_err();
        final_report();
    end
endmodule
`default_nettype wire
